// ---- rtl/pmpa_port_m_pin_arbitration.sv ----
module pmpa_port_m_pin_arbitration (
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic      [31:0]                    hrdata,
  output logic                                hreadyout,
  output logic                                hresp,
  input  wire pmpa_pkg::pmpa_enable_t         func_enable,
  input  wire pmpa_pkg::pmpa_func_out_t       func_out,
  output pmpa_pkg::pmpa_func_in_t             func_in,
  input  wire logic [pmpa_pkg::PIN_COUNT-1:0] pin_in,
  output logic      [pmpa_pkg::PIN_COUNT-1:0] pin_out,
  output logic      [pmpa_pkg::PIN_COUNT-1:0] pin_oe
);

  localparam int unsigned N = pmpa_pkg::PIN_COUNT;

  logic [N-1:0]          data_reg;
  logic [N-1:0]          data_next;
  logic [N-1:0]          dir_reg;
  logic [N-1:0]          dir_next;
  logic [N-1:0]          pin_meta_reg;
  logic [N-1:0]          pin_sync_reg;
  logic [N-1:0]          pin_out_reg;
  logic [N-1:0]          pin_oe_reg;
  logic [N-1:0]          drv_out;
  logic [N-1:0]          drv_oe;
  logic                  wr_pend_reg;
  logic [7:0]            wr_addr_reg;
  logic [31:0]           rdata_reg;
  logic [31:0]           rdata_next;
  pmpa_pkg::pmpa_func_in_t func_in_reg;
  pmpa_pkg::pmpa_func_in_t func_in_next;
  pmpa_pkg::pmpa_owner_t owner [N];

  // Bus decode
  wire        addr_phase   = hsel & hready & htrans[1];
  wire        wr_take      = addr_phase & hwrite;
  wire        rd_take      = addr_phase & ~hwrite;
  wire        wr_data_hit  = wr_pend_reg & (wr_addr_reg == pmpa_pkg::OFFS_DATA);
  wire        wr_dir_hit   = wr_pend_reg & (wr_addr_reg == pmpa_pkg::OFFS_DIRECTION);
  wire [7:0]  rd_addr      = haddr[7:0];
  wire        size_unused  = |hsize;

  // Write lands at the end of its data phase whatever the pin owner
  assign data_next = wr_data_hit ? hwdata[N-1:0] : data_reg;
  assign dir_next  = wr_dir_hit ? hwdata[N-1:0] : dir_reg;

  // A read right after a write sees the new value, hence the next-value mux
  wire [N-1:0] data_view = (dir_next & data_next) | (~dir_next & pin_sync_reg);

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd_take) begin
      unique case (rd_addr)
        pmpa_pkg::OFFS_DATA:      rdata_next[N-1:0] = data_view;
        pmpa_pkg::OFFS_DIRECTION: rdata_next[N-1:0] = dir_next;
        pmpa_pkg::OFFS_PIN_LEVEL: rdata_next[N-1:0] = pin_sync_reg;
        default:                  rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Owner chains, highest priority first
  assign owner[4] = func_enable.bus_controller_two ? pmpa_pkg::OWN_BUS_CONTROLLER_TWO :
                    func_enable.bus_controller_zero_routed ? pmpa_pkg::OWN_CAN0R :
                    func_enable.bus_controller_four_routed ? pmpa_pkg::OWN_CAN4R :
                    func_enable.serial_peripheral_unit_zero_routed ? pmpa_pkg::OWN_SERIAL_PERIPHERAL_UNIT_ZERO :
                    pmpa_pkg::OWN_GPIO;

  assign owner[3] = func_enable.bus_controller_one ? pmpa_pkg::OWN_BUS_CONTROLLER_ONE :
                    func_enable.bus_controller_zero_routed ? pmpa_pkg::OWN_CAN0R :
                    func_enable.serial_peripheral_unit_zero_routed ? pmpa_pkg::OWN_SERIAL_PERIPHERAL_UNIT_ZERO :
                    pmpa_pkg::OWN_GPIO;

  assign owner[2] = func_enable.bus_controller_one ? pmpa_pkg::OWN_BUS_CONTROLLER_ONE :
                    func_enable.bus_controller_zero_routed ? pmpa_pkg::OWN_CAN0R :
                    func_enable.serial_peripheral_unit_zero_routed ? pmpa_pkg::OWN_SERIAL_PERIPHERAL_UNIT_ZERO :
                    pmpa_pkg::OWN_GPIO;

  assign owner[1] = func_enable.bus_controller_zero ? pmpa_pkg::OWN_BUS_CONTROLLER_ZERO :
                    pmpa_pkg::OWN_GPIO;
  assign owner[0] = func_enable.bus_controller_zero ? pmpa_pkg::OWN_BUS_CONTROLLER_ZERO :
                    pmpa_pkg::OWN_GPIO;

  // Pin drivers; receive owners leave the pin undriven
  wire own4_gpio = owner[4] == pmpa_pkg::OWN_GPIO;
  wire own4_spi  = owner[4] == pmpa_pkg::OWN_SERIAL_PERIPHERAL_UNIT_ZERO;
  wire own3_gpio = owner[3] == pmpa_pkg::OWN_GPIO;
  wire own3_bus_controller_one = owner[3] == pmpa_pkg::OWN_BUS_CONTROLLER_ONE;
  wire own3_bus_controller_zero = owner[3] == pmpa_pkg::OWN_CAN0R;
  wire own3_spi  = owner[3] == pmpa_pkg::OWN_SERIAL_PERIPHERAL_UNIT_ZERO;
  wire own2_gpio = owner[2] == pmpa_pkg::OWN_GPIO;
  wire own2_bus_controller_one = owner[2] == pmpa_pkg::OWN_BUS_CONTROLLER_ONE;
  wire own2_bus_controller_zero = owner[2] == pmpa_pkg::OWN_CAN0R;
  wire own2_spi  = owner[2] == pmpa_pkg::OWN_SERIAL_PERIPHERAL_UNIT_ZERO;
  wire own1_bus_controller_zero = owner[1] == pmpa_pkg::OWN_BUS_CONTROLLER_ZERO;
  wire own0_bus_controller_zero = owner[0] == pmpa_pkg::OWN_BUS_CONTROLLER_ZERO;

  assign drv_out[4] = own4_spi ? func_out.mosi_out : data_reg[4];
  assign drv_oe[4]  = own4_spi ? func_out.mosi_oe : (own4_gpio & dir_reg[4]);

  assign drv_out[3] = own3_bus_controller_one ? func_out.one_tx :
                      own3_bus_controller_zero ? func_out.zero_routed_tx :
                      own3_spi ? func_out.select_out : data_reg[3];
  assign drv_oe[3]  = own3_bus_controller_one | own3_bus_controller_zero | (own3_spi & func_out.select_oe) |
                      (own3_gpio & dir_reg[3]);

  assign drv_out[2] = own2_spi ? func_out.miso_out : data_reg[2];
  assign drv_oe[2]  = own2_spi ? func_out.miso_oe : (own2_gpio & dir_reg[2]);

  assign drv_out[1] = own1_bus_controller_zero ? func_out.zero_tx : data_reg[1];
  assign drv_oe[1]  = own1_bus_controller_zero | dir_reg[1];
  assign drv_out[0] = data_reg[0];
  assign drv_oe[0]  = ~own0_bus_controller_zero & dir_reg[0];

  // Receive lines sit idle high when their function does not own the pin
  always_comb begin
    func_in_next                = '1;
    if (owner[4] == pmpa_pkg::OWN_BUS_CONTROLLER_TWO) begin
      func_in_next.two_rx = pin_sync_reg[4];
    end
    if (owner[4] == pmpa_pkg::OWN_CAN0R) begin
      func_in_next.zero_routed_rx = pin_sync_reg[4];
    end else if (own2_bus_controller_zero) begin
      func_in_next.zero_routed_rx = pin_sync_reg[2];
    end
    if (owner[4] == pmpa_pkg::OWN_CAN4R) begin
      func_in_next.four_routed_rx = pin_sync_reg[4];
    end
    if (own4_spi) begin
      func_in_next.mosi_in = pin_sync_reg[4];
    end
    if (own3_spi) begin
      func_in_next.select_in = pin_sync_reg[3];
    end
    if (own2_bus_controller_one) begin
      func_in_next.one_rx = pin_sync_reg[2];
    end
    if (own2_spi) begin
      func_in_next.miso_in = pin_sync_reg[2];
    end
    if (own0_bus_controller_zero) begin
      func_in_next.zero_rx = pin_sync_reg[0];
    end
  end

  // Two-flop synchroniser; only the second stage is read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_reg <= pmpa_pkg::PIN_SYNC_RESET;
      pin_sync_reg <= pmpa_pkg::PIN_SYNC_RESET;
    end else begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_reg <= pmpa_pkg::DATA_RESET;
      dir_reg  <= pmpa_pkg::DIRECTION_RESET;
    end else begin
      data_reg <= data_next;
      dir_reg  <= dir_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= wr_take;
      wr_addr_reg <= haddr[7:0];
      rdata_reg   <= rdata_next;
    end
  end

  // Registered pin drive costs a cycle but keeps the pads glitch free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_reg <= pmpa_pkg::DATA_RESET;
      pin_oe_reg  <= pmpa_pkg::DIRECTION_RESET;
      func_in_reg <= '1;
    end else begin
      pin_out_reg <= drv_out;
      pin_oe_reg  <= drv_oe;
      func_in_reg <= func_in_next;
    end
  end

  assign pin_out   = pin_out_reg;
  assign pin_oe    = pin_oe_reg;
  assign func_in   = func_in_reg;
  assign hrdata    = rdata_reg;
  assign hreadyout = 1'b1 | size_unused;
  assign hresp     = pmpa_pkg::HRESP_OKAY;

endmodule // pmpa_port_m_pin_arbitration

// ---- rtl/pmpa_pkg.sv ----
package pmpa_pkg;

  localparam int unsigned PIN_COUNT = 5;

  localparam logic [7:0] OFFS_DATA      = 8'h00;
  localparam logic [7:0] OFFS_DIRECTION = 8'h04;
  localparam logic [7:0] OFFS_PIN_LEVEL = 8'h08;

  localparam logic [PIN_COUNT-1:0] DATA_RESET      = 5'h00;
  localparam logic [PIN_COUNT-1:0] DIRECTION_RESET = 5'h00;
  localparam logic [PIN_COUNT-1:0] PIN_SYNC_RESET  = 5'h1f;

  localparam int unsigned BIT_RX_ZERO   = 0;
  localparam int unsigned BIT_TX_ZERO   = 1;
  localparam int unsigned BIT_MISO      = 2;
  localparam int unsigned BIT_SELECT    = 3;
  localparam int unsigned BIT_MOSI      = 4;

  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
  localparam logic       HRESP_OKAY        = 1'b0;
  localparam logic       LINE_IDLE         = 1'b1;

  typedef enum logic [2:0] {
    OWN_GPIO,
    OWN_BUS_CONTROLLER_ZERO,
    OWN_BUS_CONTROLLER_ONE,
    OWN_BUS_CONTROLLER_TWO,
    OWN_CAN0R,
    OWN_CAN4R,
    OWN_SERIAL_PERIPHERAL_UNIT_ZERO
  } pmpa_owner_t;

  typedef struct packed {
    logic bus_controller_zero;
    logic bus_controller_one;
    logic bus_controller_two;
    logic bus_controller_zero_routed;
    logic bus_controller_four_routed;
    logic serial_peripheral_unit_zero_routed;
  } pmpa_enable_t;

  typedef struct packed {
    logic zero_tx;
    logic one_tx;
    logic zero_routed_tx;
    logic mosi_out;
    logic mosi_oe;
    logic select_out;
    logic select_oe;
    logic miso_out;
    logic miso_oe;
  } pmpa_func_out_t;

  typedef struct packed {
    logic zero_rx;
    logic one_rx;
    logic two_rx;
    logic zero_routed_rx;
    logic four_routed_rx;
    logic mosi_in;
    logic select_in;
    logic miso_in;
  } pmpa_func_in_t;

endpackage

// ---- tb/pmpa_props.sv ----
module pmpa_props_chk (
  input wire logic                           hclk,
  input wire logic                           hresetn,
  input wire logic                           hreadyout,
  input wire logic                           hresp,
  input wire pmpa_pkg::pmpa_enable_t         func_enable,
  input wire pmpa_pkg::pmpa_func_out_t       func_out,
  input wire pmpa_pkg::pmpa_func_in_t        func_in,
  input wire logic [pmpa_pkg::PIN_COUNT-1:0] pin_out,
  input wire logic [pmpa_pkg::PIN_COUNT-1:0] pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic c0 = func_enable.bus_controller_zero;
  wire logic c1 = func_enable.bus_controller_one;
  wire logic c2 = func_enable.bus_controller_two;
  wire logic zr = func_enable.bus_controller_zero_routed;
  wire logic f4 = func_enable.bus_controller_four_routed;
  wire logic sp = func_enable.serial_peripheral_unit_zero_routed;
  // Two idle cycles so the registered line has seen the release
  sequence s_zero_off;
    !c0 [*2];
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  a_two_owns4: assert property (c2 |=> !pin_oe[4] && func_in.four_routed_rx && func_in.mosi_in)
    else $error("pin 4 not held by controller two");
  a_zr_owns4: assert property (!c2 && zr |=> !pin_oe[4] && func_in.two_rx && func_in.mosi_in)
    else $error("pin 4 not held by routed zero");
  a_f4_owns4: assert property (!c2 && !zr && f4 |=> !pin_oe[4] && func_in.mosi_in)
    else $error("pin 4 not held by routed four");
  a_spi_owns4: assert property (!c2 && !zr && !f4 && sp |=> pin_oe[4] == $past(func_out.mosi_oe)
    && (!pin_oe[4] || pin_out[4] == $past(func_out.mosi_out)))
    else $error("pin 4 not driven by serial unit");
  a_one_owns32: assert property (c1 |=> pin_oe[3] && pin_out[3] == $past(func_out.one_tx)
    && !pin_oe[2] && func_in.miso_in)
    else $error("pins 3 and 2 not held by controller one");
  a_zr_owns32: assert property (!c1 && zr |=> pin_oe[3] && !pin_oe[2]
    && pin_out[3] == $past(func_out.zero_routed_tx))
    else $error("pins 3 and 2 not held by routed zero");
  a_spi_owns32: assert property (!c1 && !zr && sp |=> pin_oe[3] == $past(func_out.select_oe)
    && pin_oe[2] == $past(func_out.miso_oe) && func_in.one_rx)
    else $error("pins 3 and 2 not held by serial unit");
  a_zero_owns10: assert property (c0 |=> pin_oe[1:0] == 2'h2 && pin_out[1] == $past(func_out.zero_tx))
    else $error("pins 1 and 0 not held by controller zero");
  a_zero_free: assert property (s_zero_off |-> func_in.zero_rx)
    else $error("receive line not idle while controller zero off");
endmodule // pmpa_props_chk
bind pmpa_port_m_pin_arbitration pmpa_props_chk u_props (.hclk, .hresetn, .hreadyout, .hresp,
  .func_enable, .func_out, .func_in, .pin_out, .pin_oe);

// ---- tb/pmpa_far_model.sv ----
module pmpa_far_model (
  input wire logic [pmpa_pkg::PIN_COUNT-1:0] pin_out,
  input wire logic [pmpa_pkg::PIN_COUNT-1:0] pin_oe,
  input wire logic [pmpa_pkg::PIN_COUNT-1:0] ext_level,
  output logic     [pmpa_pkg::PIN_COUNT-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pad shows our own drive when enabled, else the board level; no contention modelled
  always_comb for (int i = 0; i < pmpa_pkg::PIN_COUNT; i++) pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
endmodule // pmpa_far_model

// ---- tb/tb_port_m_pin_arbitration.sv ----
module tb_port_m_pin_arbitration;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0]              haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]               htrans = 2'h0;
  logic [2:0]               hsize = 3'h2;
  logic                     hreadyout, hresp;
  pmpa_pkg::pmpa_enable_t   func_enable = 6'h00;
  pmpa_pkg::pmpa_func_out_t func_out = 9'h000;
  pmpa_pkg::pmpa_func_in_t  func_in;
  logic [4:0]               pin_in, pin_out, pin_oe, ext_level = 5'h00;
  int                       miscompares = 0, checks = 0;
  always #25 hclk = ~hclk;
  pmpa_port_m_pin_arbitration u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .func_enable, .func_out, .func_in,
    .pin_in, .pin_out, .pin_oe);
  pmpa_far_model u_far (.pin_out, .pin_oe, .ext_level, .pin_in);
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic hwait;
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      end_of_test();
    end
  endtask
  // Single word transfer; read data is taken at the closing edge of the data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [4:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {27'h0, d};
    hwait();
    rd = hrdata;
  endtask
  task automatic t_gpio;
    ahb(1'b0, 8'h04, 5'h00);
    chk(rd, 32'h0);
    ahb(1'b0, 8'h0c, 5'h00);
    chk(rd, 32'h0);
    ext_level <= 5'h0a;
    ahb(1'b1, 8'h00, 5'h15);
    repeat (5) @(posedge hclk);
    ahb(1'b0, 8'h00, 5'h00);
    chk(rd, 32'h0a);
    chk(pin_oe, 5'h00);
    ahb(1'b1, 8'h04, 5'h1f);
    repeat (3) @(posedge hclk);
    chk({pin_oe, pin_out}, 10'h3f5);
    ahb(1'b1, 8'h04, 5'h03);
    // Released pads need the drive edge plus two sync stages before the board level shows
    repeat (4) @(posedge hclk);
    ahb(1'b0, 8'h00, 5'h00);
    chk(rd, 32'h09);
    ahb(1'b1, 8'h04, 5'h1f);
    ahb(1'b1, 8'h00, 5'h00);
    $display("gpio test done");
  endtask
  task automatic t_bit4;
    func_out <= 9'h030;
    ext_level <= 5'h04;
    for (int i = 0; i < 5; i++) begin
      func_enable <= {2'b00, i == 0, i <= 1, i <= 2, i <= 3};
      repeat (5) @(posedge hclk);
      chk(pin_oe[4], i > 2);
      if (i > 2) chk(pin_out[4], i == 3);
      chk({func_in.two_rx, func_in.zero_routed_rx, func_in.four_routed_rx},
          {i != 0, i != 1, i != 2});
    end
    $display("pin 4 test done");
  endtask
  task automatic t_bit32;
    func_out <= 9'h08b;
    ext_level <= 5'h00;
    for (int i = 0; i < 4; i++) begin
      // Controller two stays on so pin 4 never competes for the routed zero receive
      func_enable <= {1'b0, i == 0, 1'b1, i <= 1, 1'b0, i <= 2};
      repeat (5) @(posedge hclk);
      chk(pin_oe[3], i != 2);
      chk(func_in.select_in, i != 2);
      if (i != 2) chk(pin_out[3], i == 0);
      chk({pin_oe[2], func_in.one_rx, func_in.zero_routed_rx}, {i > 1, i != 0, i != 1});
      if (i > 1) chk(pin_out[2], i == 2);
    end
    $display("pins 3 and 2 test done");
  endtask
  task automatic t_bit10;
    func_enable <= 6'h20;
    func_out <= 9'h100;
    repeat (5) @(posedge hclk);
    chk({pin_oe[1:0], pin_out[1], func_in.zero_rx}, 4'ha);
    func_enable <= 6'h00;
    repeat (5) @(posedge hclk);
    chk({pin_oe[1:0], pin_out[1:0], func_in.zero_rx}, 5'h19);
    $display("pins 1 and 0 test done");
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_gpio();
    t_bit4();
    t_bit32();
    t_bit10();
    end_of_test();
  end
endmodule // tb_port_m_pin_arbitration
